// >>> design/timer_pwm_defs.svh
// constants of the eight-unit timer, counter and pwm block
`ifndef TIMER_PWM_DEFS_SVH
`define TIMER_PWM_DEFS_SVH

// ****************************************************************
// register map: unit select bits, word offsets within a unit, byte addresses of shared registers
// ****************************************************************
`define UNIT_COUNT      8
`define UNIT_SEL_MSB    6
`define UNIT_SEL_LSB    4
`define OFF_CTRL        2'h0
`define OFF_PERIOD      2'h1
`define OFF_COMPARE     2'h2
`define OFF_CAPTURE     2'h3
`define OFF_STATUS      9'h100
`define OFF_CLEAR       9'h104
`define OFF_INTEN       9'h108

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_EN_BIT     0
`define CTRL_HALT_BIT   1
`define CTRL_DT_LSB     8
`define CTRL_DT_MSB     15
`define CTRL_MASK       16'hFF03
`define ST_CAP_LSB      8
`define RST_CTRL        16'h0000
`define RST_PERIOD      16'hFFFF
`define RST_COMPARE     16'h8000
`define RST_INTEN       16'h0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define KILL_LEVEL      1'b0
`define DT_SAT          8'hFF

`endif

// >>> design/timer_pwm_pkg.sv
// types shared by the timer, counter and pwm block
package timer_pwm_pkg;

    // ****************************************************************
    // settings handed from the register file to one unit
    // ****************************************************************
    typedef struct packed {
        logic        run;      // counter enabled
        logic        start;    // one-cycle restart pulse
        logic        halt;     // stop at period instead of reload
        logic [7:0]  dead;     // dead-band length in cycles
        logic [15:0] period;
        logic [15:0] compare;
    } unit_cfg_t;

    // ****************************************************************
    // what one unit reports back
    // ****************************************************************
    typedef struct packed {
        logic        tc_pulse;  // period match
        logic        cap_pulse; // capture taken
        logic [15:0] capture;
    } unit_obs_t;

endpackage : timer_pwm_pkg

// >>> design/timer_pwm_top.sv
// eight timer, counter and pwm units behind an axi4-lite slave
//
// Overview of operation
// - sixteen-bit counter with software-set period
// - capture event latches counter into capture register
// - period match halts or reloads, per configuration
// - compare against counter gives pwm duty output
// - true and complement pair with dead-band offset
// - kill input forces outputs low, no software
// - eight independent units in the device
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "timer_pwm_defs.svh"

module timer_pwm_unit
    import timer_pwm_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      arst_n,
    // settings and report
    input  wire unit_cfg_t cfg,
    output unit_obs_t      obs,
    // pins
    input  wire logic      cap_pin,
    input  wire logic      kill_pin,
    output logic           line,
    output logic           line_compl
);

    typedef struct packed {
        logic [2:0]  cap_sync;
        logic [2:0]  kill_sync;
        logic        cap_lvl;
        logic        kill_lvl;
        logic        running;
        logic [15:0] count;
        logic [15:0] capture;
        logic        tc;
        logic        cap_ev;
        logic        raw;
        logic [7:0]  dt_cnt;
        logic        line;
        logic        compl;
    } unit_state_t;

    unit_state_t s_ff;
    unit_state_t nxt_s;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        nxt_s = s_ff;
        // three-stage synchronisers, first stage only feeds the second
        nxt_s.cap_sync  = {s_ff.cap_sync[1:0], cap_pin};
        nxt_s.kill_sync = {s_ff.kill_sync[1:0], kill_pin};
        if (s_ff.cap_sync[1] == s_ff.cap_sync[2]) begin
            nxt_s.cap_lvl = s_ff.cap_sync[2];
        end
        if (s_ff.kill_sync[1] == s_ff.kill_sync[2]) begin
            nxt_s.kill_lvl = s_ff.kill_sync[2];
        end
        // capture on the agreed rising edge of the event pin
        nxt_s.cap_ev = nxt_s.cap_lvl & ~s_ff.cap_lvl;
        if (nxt_s.cap_ev) begin
            nxt_s.capture = s_ff.count;
        end
        // counter run control and period match
        nxt_s.tc = 1'b0;
        if (!cfg.run) begin
            nxt_s.running = 1'b0;
        end else if (cfg.start) begin
            nxt_s.running = 1'b1;
            nxt_s.count   = 16'h0000;
        end else if (s_ff.running) begin
            if (s_ff.count == cfg.period) begin
                nxt_s.tc = 1'b1;
                if (cfg.halt) begin
                    nxt_s.running = 1'b0;
                end else begin
                    nxt_s.count = 16'h0000;
                end
            end else begin
                nxt_s.count = s_ff.count + 16'h0001;
            end
        end
        // duty signal from the compare value
        nxt_s.raw = s_ff.running && (s_ff.count < cfg.compare);
        // dead-band: a side turns on only after the gap has elapsed
        if (nxt_s.raw != s_ff.raw) begin
            nxt_s.dt_cnt = 8'h00;
        end else if (s_ff.dt_cnt != `DT_SAT) begin
            nxt_s.dt_cnt = s_ff.dt_cnt + 8'h01;
        end
        nxt_s.line  = s_ff.raw && (s_ff.dt_cnt >= cfg.dead);
        nxt_s.compl = !s_ff.raw && s_ff.running
                      && (s_ff.dt_cnt >= cfg.dead);
        // kill overrides both outputs at once
        if (nxt_s.kill_lvl) begin
            nxt_s.line  = `KILL_LEVEL;
            nxt_s.compl = `KILL_LEVEL;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // report and pin drive
    assign obs.tc_pulse  = s_ff.tc;
    assign obs.cap_pulse = s_ff.cap_ev;
    assign obs.capture   = s_ff.capture;
    assign line          = s_ff.line;
    assign line_compl    = s_ff.compl;
endmodule : timer_pwm_unit

module timer_pwm_top
    import timer_pwm_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // axi4-lite write address and data
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [8:0]  AWADDR,
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    // axi4-lite write response
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    // axi4-lite read
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [8:0]  ARADDR,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    // unit pins
    input  wire logic [7:0]  CAPTURE_IN,
    input  wire logic [7:0]  KILL_IN,
    output logic [7:0]       LINE,
    output logic [7:0]       LINE_COMPL,
    // interrupt
    output logic             IRQ
);

    typedef struct packed {
        logic [7:0][15:0] ctrl;
        logic [7:0][15:0] period;
        logic [7:0][15:0] compare;
        logic [15:0]      status;
        logic [15:0]      inten;
        logic [7:0]       start;
        logic             aw_got;
        logic [8:0]       awaddr;
        logic             w_got;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } top_state_t;

    top_state_t s_ff;
    top_state_t nxt_s;
    unit_cfg_t  cfg  [`UNIT_COUNT];
    unit_obs_t  obs  [`UNIT_COUNT];
    logic [7:0] tc_set;
    logic [7:0] cap_set;

    // merge write data into an old word under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb);
        logic [31:0] mask;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~mask) | (dat & mask);
    endfunction : merge

    // ****************************************************************
    // the eight units
    // ****************************************************************
    generate
        for (genvar i = 0; i < `UNIT_COUNT; i++) begin : g_unit
            assign cfg[i].run     = s_ff.ctrl[i][`CTRL_EN_BIT];
            assign cfg[i].start   = s_ff.start[i];
            assign cfg[i].halt    = s_ff.ctrl[i][`CTRL_HALT_BIT];
            assign cfg[i].dead    = s_ff.ctrl[i][`CTRL_DT_MSB:`CTRL_DT_LSB];
            assign cfg[i].period  = s_ff.period[i];
            assign cfg[i].compare = s_ff.compare[i];
            assign tc_set[i]      = obs[i].tc_pulse;
            assign cap_set[i]     = obs[i].cap_pulse;
            timer_pwm_unit u_unit (
                .clk        (CLK),
                .arst_n     (ARST_N),
                .cfg        (cfg[i]),
                .obs        (obs[i]),
                .cap_pin    (CAPTURE_IN[i]),
                .kill_pin   (KILL_IN[i]),
                .line       (LINE[i]),
                .line_compl (LINE_COMPL[i])
            );
        end
    endgenerate

    // ****************************************************************
    // bus slave and register file
    // ****************************************************************
    always_comb begin
        logic [15:0] clr;
        logic [31:0] wv;
        logic [2:0]  wu;
        logic [2:0]  ru;
        clr   = 16'h0000;
        wv    = 32'h0000_0000;
        wu    = 3'h0;
        ru    = 3'h0;
        nxt_s = s_ff;
        nxt_s.start = 8'h00;
        // address and data are taken in either order
        if (AWVALID && AWREADY) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = AWADDR;
        end
        if (WVALID && WREADY) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = WDATA;
            nxt_s.wstrb = WSTRB;
        end
        // perform the write once both halves are held
        if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got  = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp  = `RESP_OKAY;
            wu = s_ff.awaddr[`UNIT_SEL_MSB:`UNIT_SEL_LSB];
            if (s_ff.awaddr[8:7] == 2'h0 && s_ff.awaddr[1:0] == 2'h0) begin
                unique case (s_ff.awaddr[3:2])
                    `OFF_CTRL: begin
                        wv = merge({16'h0000, s_ff.ctrl[wu]},
                                   s_ff.wdata, s_ff.wstrb);
                        nxt_s.ctrl[wu]  = wv[15:0] & `CTRL_MASK;
                        nxt_s.start[wu] = wv[`CTRL_EN_BIT];
                    end
                    `OFF_PERIOD: begin
                        wv = merge({16'h0000, s_ff.period[wu]},
                                   s_ff.wdata, s_ff.wstrb);
                        nxt_s.period[wu] = wv[15:0];
                    end
                    `OFF_COMPARE: begin
                        wv = merge({16'h0000, s_ff.compare[wu]},
                                   s_ff.wdata, s_ff.wstrb);
                        nxt_s.compare[wu] = wv[15:0];
                    end
                    `OFF_CAPTURE: wv = 32'h0000_0000; // read-only
                endcase
            end else if (s_ff.awaddr == `OFF_CLEAR) begin
                wv  = merge(32'h0000_0000, s_ff.wdata, s_ff.wstrb);
                clr = wv[15:0];
            end else if (s_ff.awaddr == `OFF_INTEN) begin
                wv = merge({16'h0000, s_ff.inten}, s_ff.wdata, s_ff.wstrb);
                nxt_s.inten = wv[15:0];
            end else if (s_ff.awaddr != `OFF_STATUS) begin
                nxt_s.bresp = `RESP_SLVERR; // status ignores writes
            end
        end
        if (s_ff.bvalid && BREADY) begin
            nxt_s.bvalid = 1'b0;
        end
        // sticky events, a set in the clearing cycle wins
        nxt_s.status = (s_ff.status & ~clr) | {cap_set, tc_set};
        // read channel
        if (s_ff.rvalid && RREADY) begin
            nxt_s.rvalid = 1'b0;
        end
        if (ARVALID && ARREADY) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = `RESP_OKAY;
            nxt_s.rdata  = 32'h0000_0000;
            ru = ARADDR[`UNIT_SEL_MSB:`UNIT_SEL_LSB];
            if (ARADDR[8:7] == 2'h0 && ARADDR[1:0] == 2'h0) begin
                unique case (ARADDR[3:2])
                    `OFF_CTRL:    nxt_s.rdata[15:0] = s_ff.ctrl[ru];
                    `OFF_PERIOD:  nxt_s.rdata[15:0] = s_ff.period[ru];
                    `OFF_COMPARE: nxt_s.rdata[15:0] = s_ff.compare[ru];
                    `OFF_CAPTURE: nxt_s.rdata[15:0] = obs[ru].capture;
                endcase
            end else if (ARADDR == `OFF_STATUS) begin
                nxt_s.rdata[15:0] = s_ff.status;
            end else if (ARADDR == `OFF_INTEN) begin
                nxt_s.rdata[15:0] = s_ff.inten;
            end else if (ARADDR != `OFF_CLEAR) begin
                nxt_s.rresp = `RESP_SLVERR; // clear reads back zero
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_ff         <= '0;
            s_ff.ctrl    <= {`UNIT_COUNT{`RST_CTRL}};
            s_ff.period  <= {`UNIT_COUNT{`RST_PERIOD}};
            s_ff.compare <= {`UNIT_COUNT{`RST_COMPARE}};
            s_ff.inten   <= `RST_INTEN;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // handshake and answer outputs
    assign AWREADY = !s_ff.aw_got && !s_ff.bvalid;
    assign WREADY  = !s_ff.w_got && !s_ff.bvalid;
    assign BVALID  = s_ff.bvalid;
    assign BRESP   = s_ff.bresp;
    assign ARREADY = !s_ff.rvalid;
    assign RVALID  = s_ff.rvalid;
    assign RDATA   = s_ff.rdata;
    assign RRESP   = s_ff.rresp;
    assign IRQ     = |(s_ff.status & s_ff.inten);
endmodule : timer_pwm_top

// >>> tb/timer_pwm_sva.sv
// concurrent checks on the bus and pwm pins of the timer block
`timescale 1ns/1ps
module timer_pwm_sva (
    // clock and reset
    input wire logic        CLK,
    input wire logic        ARST_N,
    // register bus
    input wire logic        AWREADY,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [8:0]  ARADDR,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    // unit pins
    input wire logic [7:0]  KILL_IN,
    input wire logic [7:0]  LINE,
    input wire logic [7:0]  LINE_COMPL,
    input wire logic        IRQ
);
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    AST_RESET_QUIET: assert property ($rose(ARST_N) |->
        LINE == 8'h00 && LINE_COMPL == 8'h00 && !IRQ)
        else $error("outputs active after reset");
    AST_KILL_SAFE: assert property ((KILL_IN == 8'hFF) [*7] |->
        LINE == 8'h00 && LINE_COMPL == 8'h00)
        else $error("outputs driven under kill");
    AST_NO_SHOOT: assert property ((LINE & LINE_COMPL) == 8'h00)
        else $error("true and complement high together");
    AST_B_HOLD: assert property (BVALID && !BREADY |=>
        BVALID && $stable(BRESP)) else $error("write response dropped");
    AST_R_HOLD: assert property (RVALID && !RREADY |=>
        RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read data dropped");
    AST_AR_READY: assert property (ARREADY == !RVALID)
        else $error("read address ready wrong");
    AST_RD_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_MISALIGN: assert property (ARVALID && ARREADY &&
        ARADDR[1:0] != 2'h0 |=> RRESP == 2'h2)
        else $error("misaligned read not refused");
    AST_W_REFUSE: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while response pending");
endmodule : timer_pwm_sva

bind timer_pwm_top timer_pwm_sva chk (.CLK(CLK), .ARST_N(ARST_N),
    .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .KILL_IN(KILL_IN),
    .LINE(LINE), .LINE_COMPL(LINE_COMPL), .IRQ(IRQ));

// >>> tb/event_source.sv
// model of the event sources and power stage around the pwm pins
`timescale 1ns/1ps
module event_source (
    // clock
    input wire logic       CLK,
    // pwm pins
    input wire logic [7:0] LINE,
    input wire logic [7:0] LINE_COMPL,
    // event pins
    output logic [7:0]     CAPTURE_IN,
    output logic [7:0]     KILL_IN
);
    int overlap = 0;

    // pins idle low
    initial begin
        CAPTURE_IN = 8'h00;
        KILL_IN = 8'h00;
    end

    // count cycles where both switches of one leg would conduct
    always @(posedge CLK) begin
        if ((LINE & LINE_COMPL) != 8'h00)
            overlap <= overlap + 1;
    end

    // one capture edge, held long enough to pass the pin filter
    task strike(input int n);
        @(posedge CLK);
        CAPTURE_IN[n] <= 1'b1;
        repeat (6) @(posedge CLK);
        CAPTURE_IN[n] <= 1'b0;
    endtask : strike

    // overcurrent alarm lines
    task trip(input logic [7:0] m);
        @(posedge CLK);
        KILL_IN <= m;
    endtask : trip
endmodule : event_source

// >>> tb/test_timer_counter_pwm_unit.sv
// register-level tests of the eight-unit timer and pwm block
`timescale 1ns/1ps
module test_timer_counter_pwm_unit;
    logic        CLK;
    logic        ARST_N;
    logic        AWVALID;
    logic        WVALID;
    logic        BREADY;
    logic        ARVALID;
    logic        RREADY;
    logic [8:0]  AWADDR;
    logic [8:0]  ARADDR;
    logic [31:0] WDATA;
    logic [3:0]  WSTRB;
    wire         AWREADY;
    wire         WREADY;
    wire         BVALID;
    wire         ARREADY;
    wire         RVALID;
    wire         IRQ;
    wire [1:0]   BRESP;
    wire [1:0]   RRESP;
    wire [31:0]  RDATA;
    wire [7:0]   CAPTURE_IN;
    wire [7:0]   KILL_IN;
    wire [7:0]   LINE;
    wire [7:0]   LINE_COMPL;
    int          num_errors = 0;
    int          checked = 0;
    int          hi_n;
    int          lo_n;
    int          h0;
    int          l0;

    timer_pwm_top uut (.CLK(CLK), .ARST_N(ARST_N), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID),
        .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
        .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID),
        .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .CAPTURE_IN(CAPTURE_IN), .KILL_IN(KILL_IN), .LINE(LINE),
        .LINE_COMPL(LINE_COMPL), .IRQ(IRQ));
    event_source src (.CLK(CLK), .LINE(LINE), .LINE_COMPL(LINE_COMPL),
        .CAPTURE_IN(CAPTURE_IN), .KILL_IN(KILL_IN));

    // ****************************************************************
    // clock and bus tasks
    // ****************************************************************
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    // compare one value and count it
    task chk(input string nm, input logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one write, address and data offered together
    task wr(input logic [8:0] a, logic [31:0] v, logic [3:0] s,
            logic [1:0] er);
        @(posedge CLK);
        AWVALID <= 1'b1;
        AWADDR <= a;
        WVALID <= 1'b1;
        WDATA <= v;
        WSTRB <= s;
        BREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
            if (BVALID && BREADY) begin
                BREADY <= 1'b0;
                chk("bresp", BRESP, er);
                break;
            end
        end
    endtask : wr

    // one read; data compared only when an okay answer is expected
    task rd(input logic [8:0] a, logic [31:0] ev, logic [1:0] er,
            string nm);
        @(posedge CLK);
        ARVALID <= 1'b1;
        ARADDR <= a;
        RREADY <= 1'b1;
        forever begin
            @(posedge CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
            if (RVALID && RREADY) begin
                RREADY <= 1'b0;
                chk("rresp", RRESP, er);
                if (er == 2'h0) chk(nm, RDATA, ev);
                break;
            end
        end
    endtask : rd

    // high cycles of both lines of a unit over four whole periods
    task meas(input int u);
        hi_n = 0;
        lo_n = 0;
        repeat (10) @(posedge CLK);
        repeat (40) begin
            @(posedge CLK);
            hi_n += LINE[u];
            lo_n += LINE_COMPL[u];
        end
    endtask : meas

    // counts, verdict and end of run
    task close_out();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        ARST_N = 1'b0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
        AWADDR = 9'h000;
        ARADDR = 9'h000;
        WDATA = 32'h0000_0000;
        WSTRB = 4'hF;
        repeat (12) @(posedge CLK);
        ARST_N <= 1'b1;
        for (int u = 0; u < 8; u++) begin
            rd(9'(u * 16), 32'h0, 2'h0, "ctrl");
            rd(9'(u * 16 + 4), 32'hFFFF, 2'h0, "period");
            rd(9'(u * 16 + 8), 32'h8000, 2'h0, "compare");
        end
        chk("irq", IRQ, 1'b0);
        $display("test reset values done");
        rd(9'h1F0, 32'h0, 2'h2, "unmapped");
        rd(9'h006, 32'h0, 2'h2, "misaligned");
        wr(9'h1F0, 32'h1, 4'hF, 2'h2);
        wr(9'h100, 32'hFFFF, 4'hF, 2'h0);
        rd(9'h100, 32'h0, 2'h0, "status ro");
        wr(9'h004, 32'h1234, 4'h1, 2'h0);
        rd(9'h004, 32'hFF34, 2'h0, "strobe");
        $display("test bus refusals done");
        wr(9'h014, 32'h9, 4'hF, 2'h0);
        wr(9'h018, 32'h4, 4'hF, 2'h0);
        wr(9'h010, 32'h1, 4'hF, 2'h0);
        meas(1);
        chk("duty", hi_n, 16);
        chk("compl", lo_n, 24);
        h0 = hi_n;
        l0 = lo_n;
        wr(9'h010, 32'h0301, 4'hF, 2'h0);
        meas(1);
        chk("dead line", h0 - hi_n, 12);
        chk("dead compl", l0 - lo_n, 12);
        rd(9'h100, 32'h0002, 2'h0, "match");
        chk("irq masked", IRQ, 1'b0);
        wr(9'h108, 32'h2, 4'hF, 2'h0);
        chk("irq", IRQ, 1'b1);
        wr(9'h010, 32'h0, 4'hF, 2'h0);
        repeat (5) @(posedge CLK);
        chk("stopped", {LINE[1], LINE_COMPL[1]}, 2'h0);
        wr(9'h104, 32'h2, 4'hF, 2'h0);
        chk("irq clear", IRQ, 1'b0);
        $display("test duty and dead band done");
        wr(9'h034, 32'h5, 4'hF, 2'h0);
        wr(9'h030, 32'h3, 4'hF, 2'h0);
        repeat (20) @(posedge CLK);
        src.strike(3);
        repeat (10) @(posedge CLK);
        rd(9'h03C, 32'h5, 2'h0, "capture");
        rd(9'h100, 32'h0808, 2'h0, "status");
        $display("test halt and capture done");
        wr(9'h010, 32'h1, 4'hF, 2'h0);
        src.trip(8'hFF);
        repeat (10) @(posedge CLK);
        chk("kill", {LINE, LINE_COMPL}, 16'h0);
        src.trip(8'h00);
        meas(1);
        chk("resume", hi_n, 16);
        chk("overlap", src.overlap, 0);
        $display("test kill done");
        close_out();
    end

    // cut a hang short
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule : test_timer_counter_pwm_unit
